// file: nvc_defs.vh
// Constants for the serial nvSRAM host command controller
`ifndef NVC_DEFS_VH
`define NVC_DEFS_VH

// ----------------------------------------------------------------
// Device opcodes
// ----------------------------------------------------------------
`define NVC_OP_LATCH_SET   8'h06
`define NVC_OP_LATCH_CLR   8'h04
`define NVC_OP_STAT_RD     8'h05
`define NVC_OP_STAT_WR     8'h01
`define NVC_OP_ARR_RD      8'h03
`define NVC_OP_ARR_WR      8'h02
`define NVC_OP_CRC_RD      8'h13
`define NVC_OP_CRC_WR      8'h12
`define NVC_OP_STORE       8'h08
`define NVC_OP_RECALL      8'h09
`define NVC_OP_SN_WR       8'hC2
`define NVC_OP_SN_RD       8'hC3
`define NVC_OP_HIBERNATE   8'hB9

// ----------------------------------------------------------------
// Device status_and_protection fields
// ----------------------------------------------------------------
`define NVC_SR_BUSY        0
`define NVC_SR_WEL         1
`define NVC_SR_BP_LO       2
`define NVC_SR_BP_HI       3
`define NVC_SR_CRCERR      4
`define NVC_SR_PSOFF       6
`define NVC_SR_PPEN        7

// ----------------------------------------------------------------
// Host register map (4-bit index)
// ----------------------------------------------------------------
`define NVC_ADDR_CMD       4'h0
`define NVC_ADDR_TXD       4'h1
`define NVC_ADDR_CTRL      4'h2
`define NVC_ADDR_STAT      4'h3
`define NVC_ADDR_RXD       4'h4

`define NVC_CTL_HOLD       0
`define NVC_CTL_WPN        1
`define NVC_CTL_CPOL       2
`define NVC_CTL_ABORT      3

`define NVC_ST_BUSY        0
`define NVC_ST_ERR         1
`define NVC_ST_HELD        2
`define NVC_ST_WEL         3
`define NVC_ST_PWR         4
`define NVC_ST_DEV_LSB     8

// ----------------------------------------------------------------
// Frame lengths and timing
// ----------------------------------------------------------------
`define NVC_BITS_OP        5'h08
`define NVC_BITS_OPDAT     5'h10
`define NVC_CLK_NS         8'h08
`define NVC_SCK_HALF_NS    8'h20

`endif

// file: nvc_sync.v
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module nvc_sync #(
  parameter W = 2
) (
  // Clock and reset
  input  wire         clk,
  input  wire         resetn,
  // Data
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule

`default_nettype wire

// file: nvc_tick.v
// Half-period enable divider for the serial clock
`timescale 1ns/1ps
`default_nettype none

module nvc_tick #(
  parameter [7:0] HALF = 8'h04
) (
  // Clock and reset
  input  wire clk,
  input  wire resetn,
  // Control
  input  wire run,
  output reg  tick
);

  localparam [7:0] LAST = HALF - 8'h01;

  reg [7:0] cnt_q;

  // Restarts on every run so the first half period is always whole
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 8'h00;
      tick  <= 1'b0;
    end else if (!run) begin
      cnt_q <= 8'h00;
      tick  <= 1'b0;
    end else if (cnt_q == LAST) begin
      cnt_q <= 8'h00;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      tick  <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// file: nvc_host.v
// Host-side SPI command controller for a serial nvSRAM
`timescale 1ns/1ps
`default_nettype none
`include "nvc_defs.vh"

module nvc_host #(
  parameter [7:0] HALF =
    (`NVC_SCK_HALF_NS + `NVC_CLK_NS - 8'h01) / `NVC_CLK_NS
) (
  // Clock and reset
  input  wire        clk,
  input  wire        resetn,
  // Register port
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  // Device pins
  output reg         ce_n_o,
  output reg         sck_o,
  output reg         si_o,
  output reg         hold_n_o,
  output reg         wp_n_o,
  input  wire        so_i,
  // Supply sense pin
  input  wire        pwr_ok_i
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [5:0] S_IDLE  = 6'h01;
  localparam [5:0] S_LEAD  = 6'h02;
  localparam [5:0] S_SHIFT = 6'h04;
  localparam [5:0] S_HOLD  = 6'h08;
  localparam [5:0] S_TRAIL = 6'h10;
  localparam [5:0] S_GAP   = 6'h20;

  // ----------------------------------------------------------------
  // Opcode helpers
  // ----------------------------------------------------------------
  // Frame length: status read and write carry one data byte
  function [4:0] op_bits;
    input [7:0] op;
    begin
      case (op)
        `NVC_OP_STAT_RD: op_bits = `NVC_BITS_OPDAT;
        `NVC_OP_STAT_WR: op_bits = `NVC_BITS_OPDAT;
        default:         op_bits = `NVC_BITS_OP;
      endcase
    end
  endfunction

  // Instructions whose completion drops the device latch
  function op_drops_latch;
    input [7:0] op;
    begin
      case (op)
        `NVC_OP_LATCH_CLR: op_drops_latch = 1'b1;
        `NVC_OP_STAT_WR:   op_drops_latch = 1'b1;
        `NVC_OP_ARR_WR:    op_drops_latch = 1'b1;
        `NVC_OP_CRC_WR:    op_drops_latch = 1'b1;
        `NVC_OP_SN_WR:     op_drops_latch = 1'b1;
        default:           op_drops_latch = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and divider
  // ----------------------------------------------------------------
  wire [1:0] pin_s;
  wire       so_s;
  wire       pwr_s;
  wire       tick;
  reg  [5:0] state_q;

  nvc_sync #(
    .W      (2)
  ) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .d_i    ({pwr_ok_i, so_i}),
    .q_o    (pin_s)
  );

  assign so_s  = pin_s[0];
  assign pwr_s = pin_s[1];

  nvc_tick #(
    .HALF   (HALF)
  ) u_tick (
    .clk    (clk),
    .resetn (resetn),
    .run    (state_q != S_IDLE),
    .tick   (tick)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [7:0]  op_q;
  reg  [7:0]  txd_q;
  reg  [7:0]  rxd_q;
  reg  [15:0] sh_q;
  reg  [7:0]  rx_q;
  reg  [4:0]  cnt_q;
  reg  [4:0]  nbits_q;
  reg         ctl_hold_q;
  reg         ctl_cpol_q;
  reg         err_q;
  reg         wel_q;

  wire is_idle  = (state_q == S_IDLE);
  wire cmd_wr   = reg_wr && (reg_addr == `NVC_ADDR_CMD);
  wire ctl_wr   = reg_wr && (reg_addr == `NVC_ADDR_CTRL);
  wire stat_wr  = reg_wr && (reg_addr == `NVC_ADDR_STAT);
  wire abort    = (ctl_wr && reg_wdata[`NVC_CTL_ABORT]) || !pwr_s;
  // Status write without a prior latch set would be discarded
  wire refuse   = cmd_wr && (!is_idle || !pwr_s ||
                  ((reg_wdata[7:0] == `NVC_OP_STAT_WR) && !wel_q));
  wire start    = cmd_wr && !refuse;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txd_q      <= 8'h00;
      ctl_hold_q <= 1'b0;
      ctl_cpol_q <= 1'b0;
      wp_n_o     <= 1'b1;
      err_q      <= 1'b0;
    end else begin
      if (reg_wr && (reg_addr == `NVC_ADDR_TXD))
        txd_q <= reg_wdata[7:0];
      if (ctl_wr) begin
        ctl_hold_q <= reg_wdata[`NVC_CTL_HOLD];
        ctl_cpol_q <= reg_wdata[`NVC_CTL_CPOL];
        wp_n_o     <= reg_wdata[`NVC_CTL_WPN];
      end
      // Set beats write-one clear in the same cycle
      if (refuse)
        err_q <= 1'b1;
      else if (stat_wr && reg_wdata[`NVC_ST_ERR])
        err_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `NVC_ADDR_CMD:  reg_rdata <= {8'h00, op_q};
        `NVC_ADDR_TXD:  reg_rdata <= {8'h00, txd_q};
        `NVC_ADDR_CTRL: reg_rdata <= {12'h000, 1'b0, ctl_cpol_q,
                                      wp_n_o, ctl_hold_q};
        `NVC_ADDR_STAT: reg_rdata <= {1'b0,
                          rxd_q[`NVC_SR_PPEN],
                          rxd_q[`NVC_SR_PSOFF],
                          rxd_q[`NVC_SR_CRCERR],
                          rxd_q[`NVC_SR_BP_HI:`NVC_SR_BP_LO],
                          rxd_q[`NVC_SR_WEL],
                          rxd_q[`NVC_SR_BUSY],
                          3'h0, pwr_s, wel_q,
                          (state_q == S_HOLD), err_q, !is_idle};
        `NVC_ADDR_RXD:  reg_rdata <= {8'h00, rxd_q};
        default:        reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q  <= S_IDLE;
      ce_n_o   <= 1'b1;
      sck_o    <= 1'b0;
      si_o     <= 1'b0;
      hold_n_o <= 1'b1;
      op_q     <= 8'h00;
      sh_q     <= 16'h0000;
      rx_q     <= 8'h00;
      rxd_q    <= 8'h00;
      cnt_q    <= 5'h00;
      nbits_q  <= 5'h00;
      wel_q    <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          sck_o <= ctl_cpol_q;
          if (!pwr_s)
            wel_q <= 1'b0;
          if (start) begin
            op_q    <= reg_wdata[7:0];
            sh_q    <= {reg_wdata[7:0], txd_q};
            si_o    <= reg_wdata[7];
            nbits_q <= op_bits(reg_wdata[7:0]);
            cnt_q   <= 5'h00;
            ce_n_o  <= 1'b0;
            state_q <= S_LEAD;
          end
        end
        S_LEAD: begin
          if (abort) begin
            ce_n_o  <= 1'b1;
            state_q <= S_GAP;
          end else if (tick) begin
            sck_o   <= 1'b0;
            state_q <= S_SHIFT;
          end
        end
        S_SHIFT: begin
          if (abort) begin
            // Partial opcode never reaches the latch shadow
            ce_n_o  <= 1'b1;
            // Clock drops with the deselect so no edge is left half done
            sck_o   <= 1'b0;
            state_q <= S_GAP;
          end else if (tick) begin
            if (!sck_o) begin
              if (ctl_hold_q) begin
                hold_n_o <= 1'b0;
                state_q  <= S_HOLD;
              end else begin
                sck_o <= 1'b1;
                rx_q  <= {rx_q[6:0], so_s};
                cnt_q <= cnt_q + 5'h01;
              end
            end else begin
              sck_o <= 1'b0;
              if (cnt_q == nbits_q) begin
                state_q <= S_TRAIL;
              end else begin
                sh_q <= {sh_q[14:0], 1'b0};
                si_o <= sh_q[14];
              end
            end
          end
        end
        S_HOLD: begin
          if (abort) begin
            // Device drops the frame when CE rises in hold
            ce_n_o   <= 1'b1;
            hold_n_o <= 1'b1;
            state_q  <= S_GAP;
          end else if (tick && !ctl_hold_q) begin
            hold_n_o <= 1'b1;
            state_q  <= S_SHIFT;
          end
        end
        S_TRAIL: begin
          // Deselect in the clock-low time after the last bit
          ce_n_o  <= 1'b1;
          state_q <= S_GAP;
          if (op_q == `NVC_OP_LATCH_SET)
            wel_q <= 1'b1;
          else if (op_drops_latch(op_q))
            wel_q <= 1'b0;
          if (op_q == `NVC_OP_STAT_RD)
            rxd_q <= rx_q;
        end
        S_GAP: begin
          if (!pwr_s)
            wel_q <= 1'b0;
          if (tick) begin
            sck_o   <= ctl_cpol_q;
            state_q <= S_IDLE;
          end
        end
        default: begin
          ce_n_o   <= 1'b1;
          hold_n_o <= 1'b1;
          state_q  <= S_IDLE;
        end
      endcase
    end
  end

  // Unknown opcodes are still framed normally; the device
  // ignores them and the next select re-arms it.
  // Protection decoding stays with software
  // which reads the device byte from the status register.
  // Store, recall and hibernate are plain one-byte frames.

endmodule

`default_nettype wire

// file: snc_props.sv
// Port-level checker for the nvSRAM host controller
`timescale 1ns/1ps
`default_nettype none
module snc_props #(
  parameter [7:0] HALF = 8'h04
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // Register port
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // Device pins
  input wire logic        ce_n_o,
  input wire logic        sck_o,
  input wire logic        si_o,
  input wire logic        hold_n_o,
  input wire logic        wp_n_o,
  input wire logic        so_i,
  input wire logic        pwr_ok_i
);
  // ----------------------------------------------------------------
  // Link timing
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // Lead phase keeps the clock still; sized for a half period of 4
  sequence s_lead;
    $stable(sck_o)[*4];
  endsequence
  sequence s_half;
    ($stable(sck_o) || ce_n_o)[*3];
  endsequence

  a_lead_still: assert property ($fell(ce_n_o) |-> s_lead)
    else $error("serial clock moved in frame lead");
  a_half_period: assert property (!ce_n_o && $changed(sck_o) |=> s_half)
    else $error("serial clock half period too short");
  a_data_on_low: assert property (
    !ce_n_o && !$past(ce_n_o) && $changed(si_o) |-> !sck_o)
    else $error("serial data changed with clock high");
  a_hold_clk_low: assert property ($changed(hold_n_o) |-> !sck_o)
    else $error("hold moved with clock high");
  a_hold_selected: assert property ($fell(hold_n_o) |-> !ce_n_o)
    else $error("hold entered while deselected");
  a_ce_end_low: assert property ($rose(ce_n_o) |-> !sck_o)
    else $error("chip enable rose with clock high");
  a_wp_pin_level: assert property (
    reg_wr && reg_addr == 4'h2 |=> wp_n_o == $past(reg_wdata[1]))
    else $error("protect pin does not follow control");
  a_pwr_gate: assert property ((!pwr_ok_i) [*5] |-> ce_n_o)
    else $error("device selected with supply low");
endmodule

bind nvc_host snc_props #(.HALF(HALF)) chk_u (
  .clk(clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .ce_n_o(ce_n_o), .sck_o(sck_o), .si_o(si_o),
  .hold_n_o(hold_n_o), .wp_n_o(wp_n_o), .so_i(so_i), .pwr_ok_i(pwr_ok_i)
);
`default_nettype wire

// file: snc_dev.sv
// Behavioural serial nvSRAM model, command and status path only
`timescale 1ns/1ps
`default_nettype none
module snc_dev (
  // Device pins
  input  wire logic ce_n,
  input  wire logic sck,
  input  wire logic si,
  input  wire logic hold_n,
  input  wire logic wp_n,
  output var  logic so
);
  // ----------------------------------------------------------------
  // Shift and status state
  // ----------------------------------------------------------------
  logic [7:0] sh_q, op_q, st_q, nv_q;
  logic [4:0] n_q;
  logic       wel_q;

  initial begin
    {sh_q, op_q, st_q, nv_q, n_q, wel_q, so} = '0;
  end

  always @(negedge ce_n) begin
    n_q = 5'h00;
    op_q = 8'h00;
  end

  // Every opcode but status write (01) stops the shifter after eight bits until the next select
  always @(posedge sck) begin
    if (!ce_n && hold_n &&
        (n_q < 5'h08 || (op_q == 8'h01 && n_q < 5'h10))) begin
      sh_q = {sh_q[6:0], si};
      n_q = n_q + 5'h01;
      if (n_q == 5'h08) begin
        op_q = sh_q;
        st_q = {nv_q[7:6], 2'b00, nv_q[3:2], wel_q, 1'b0};
      end
    end
  end

  always @(negedge sck) begin
    if (!ce_n && hold_n && op_q == 8'h05 && n_q >= 5'h08) begin
      so = st_q[7];
      st_q = {st_q[6:0], 1'b0};
    end
  end

  // Released line flips at every deselect, so a second deselect shows the stale valid bit again
  always @(posedge ce_n) begin
    so = ~so;
    if (n_q == 5'h08 && op_q == 8'h06) wel_q = 1'b1;
    if (n_q == 5'h08 && op_q == 8'h04) wel_q = 1'b0;
    if (n_q == 5'h10 && op_q == 8'h01 && wel_q) begin
      if (!(nv_q[7] && !wp_n)) nv_q = sh_q & 8'hCC;
      wel_q = 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: test_spi_nvsram_command_status.sv
// Self-checking bench for the nvSRAM host controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); \
  end \
end
module test_spi_nvsram_command_status;
  logic        clk, resetn, reg_wr, reg_rd, pwr_ok;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, v;
  logic        ce_n, sck, si, hold_n, wp_n, so;
  int          n_mismatch, samples_checked, n_fr, cyc;

  nvc_host #(.HALF(8'h04)) dut_u (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ce_n_o(ce_n), .sck_o(sck), .si_o(si),
    .hold_n_o(hold_n), .wp_n_o(wp_n), .so_i(so), .pwr_ok_i(pwr_ok)
  );
  snc_dev p_u (
    .ce_n(ce_n), .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n),
    .so(so)
  );

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic idle;
    logic [15:0] s;
    int k;
    s = 16'h0001;
    k = 0;
    repeat (2) @(posedge clk);
    while (s[0] !== 1'b0 && k < 500) begin
      rd(4'h3, s);
      k++;
    end
    `CHK(s[0], 1'b0)
  endtask
  task automatic cmd(input logic [7:0] op);
    wr(4'h0, {8'h00, op});
    idle;
  endtask
  task automatic rds(output logic [15:0] d);
    cmd(8'h05);
    rd(4'h4, d);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    `CHK({ce_n, hold_n, wp_n}, 3'b111)
    rd(4'h3, v);
    `CHK(v, 16'h0010)
    rd(4'h5, v);
    `CHK(v, 16'h0000)
  endtask
  task automatic t_refuse;
    int f;
    f = n_fr;
    cmd(8'h01);
    `CHK(n_fr, f)
    rd(4'h3, v);
    `CHK(v & 16'h0002, 16'h0002)
    wr(4'h3, 16'h0002);
    rd(4'h3, v);
    `CHK(v & 16'h0002, 16'h0000)
  endtask
  task automatic t_latch;
    cmd(8'h06);
    rds(v);
    `CHK(v, 16'h0002)
    rd(4'h3, v);
    `CHK(v & 16'h0008, 16'h0008)
    wr(4'h2, 16'h0000);
    cmd(8'h04);
    rds(v);
    `CHK(v, 16'h0000)
    wr(4'h2, 16'h0002);
  endtask
  task automatic t_stwr;
    cmd(8'h06);
    wr(4'h1, 16'h00DF);
    cmd(8'h01);
    rds(v);
    `CHK(v, 16'h00CC)
    rd(4'h3, v);
    `CHK(v & 16'h7F00, 16'h6C00)
    wr(4'h2, 16'h0000);
    cmd(8'h06);
    wr(4'h1, 16'h0000);
    cmd(8'h01);
    rds(v);
    `CHK(v, 16'h00CC)
    wr(4'h2, 16'h0002);
    cmd(8'h06);
    cmd(8'h01);
    rds(v);
    `CHK(v, 16'h0000)
  endtask
  task automatic t_ops;
    logic [7:0] ops [10] = '{8'h03, 8'h02, 8'h13, 8'h12, 8'h08,
                             8'h09, 8'hC2, 8'hC3, 8'hB9, 8'hA5};
    foreach (ops[i]) begin
      cmd(ops[i]);
      `CHK(p_u.op_q, ops[i])
      rd(4'h0, v);
      `CHK(v, {8'h00, ops[i]})
    end
  endtask
  task automatic t_mode3;
    wr(4'h2, 16'h0006);
    rd(4'h2, v);
    `CHK(v, 16'h0006)
    repeat (3) @(posedge clk);
    `CHK(sck, 1'b1)
    cmd(8'h06);
    rds(v);
    `CHK(v, 16'h0002)
    cmd(8'h04);
    wr(4'h2, 16'h0002);
  endtask
  task automatic t_hold;
    cmd(8'h06);
    wr(4'h0, 16'h0005);
    wr(4'h2, 16'h0003);
    repeat (20) @(posedge clk);
    `CHK(hold_n, 1'b0)
    rd(4'h3, v);
    `CHK(v & 16'h0005, 16'h0005)
    wr(4'h2, 16'h0002);
    idle;
    rd(4'h4, v);
    `CHK(v, 16'h0002)
  endtask
  task automatic t_abort;
    cmd(8'h04);
    wr(4'h0, 16'h0006);
    // Cut the opcode after two bits, with the clock high
    repeat (16) @(posedge clk);
    wr(4'h2, 16'h000A);
    idle;
    rd(4'h3, v);
    `CHK(v & 16'h0008, 16'h0000)
    rds(v);
    `CHK(v, 16'h0000)
  endtask
  task automatic t_pwr;
    int f;
    f = n_fr;
    @(posedge clk);
    pwr_ok <= 1'b0;
    repeat (5) @(posedge clk);
    wr(4'h0, 16'h0006);
    rd(4'h3, v);
    `CHK(v & 16'h0012, 16'h0002)
    `CHK(n_fr, f)
    @(posedge clk);
    pwr_ok <= 1'b1;
    repeat (5) @(posedge clk);
    wr(4'h3, 16'h0002);
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(negedge ce_n) n_fr++;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out;
    end
  end
  initial begin
    {resetn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    pwr_ok = 1'b1;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
    t_refuse;
    t_latch;
    t_stwr;
    t_ops;
    t_mode3;
    t_hold;
    t_abort;
    t_pwr;
    close_out;
  end
endmodule
`default_nettype wire
